// ### hdl/cpu_seq_ctl.sv
`timescale 1ns/1ps
module cpu_seq_ctl
   import cpu_seq_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic int_req,
   input wire logic hold_req,
   input wire logic ready,
   input wire logic cpu_reset,
   input wire logic [2:0] cyc_len,
   input wire logic cyc_read,
   input wire logic cyc_fetch,
   input wire logic cyc_pc_src,
   input wire logic cyc_last,
   input wire logic [7:0] cyc_status_misc,
   input wire logic [15:0] cyc_addr,
   input wire logic [7:0] cyc_wdata,
   input wire logic halt_instruction,
   input wire logic ie_set,
   input wire logic ie_clr,
   input wire logic pc_load,
   input wire logic [15:0] pc_load_value,
   input wire logic [7:0] data_in,
   output logic [7:0] state_out,
   output logic sync_out,
   output logic first_fetch_status,
   output logic irq_ack_status,
   output logic irq_enable_flag,
   output logic data_in_strobe,
   output logic bus_grant_ack,
   output logic [15:0] addr_out,
   output logic addr_oe,
   output logic [7:0] data_out,
   output logic data_oe,
   output logic [15:0] pc_out,
   output logic [7:0] instr_out,
   output logic push_req,
   output logic [15:0] push_data
);

   // ----------------------------------------------------------------
   // Reset release and pin synchronisers
   // ----------------------------------------------------------------
   logic rst_meta_reg;
   logic rst_n;
   logic int_s, hold_s, ready_s, reset_s;

   // Reset asserts at once and releases after two edges.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   pin_sync #(.WIDTH(4)) u_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .pin_in({int_req, hold_req, ready, cpu_reset}),
      .pin_out({int_s, hold_s, ready_s, reset_s})
   );

   // ----------------------------------------------------------------
   // State sequencing
   // ----------------------------------------------------------------
   cpu_state_t state_reg, state_next;
   logic hold_latch_reg, int_latch_reg, int_cycle_reg, halt_pend_reg, halt_ret_reg;
   logic [15:0] pc_reg, rst_target;
   logic last_state, int_set, int_take, cyc_end, is_rst, hold_set, rst_hit;
   cpu_state_t end_state;

   // Final state of the current machine cycle and of the instruction.
   assign cyc_end = (state_reg == S_T3 && cyc_len == CYC_LEN_MIN) ||
                    (state_reg == S_T4 && cyc_len == CYC_LEN_MID) || (state_reg == S_T5);
   assign last_state = cyc_end && cyc_last;
   assign end_state = hold_latch_reg ? S_HOLD : S_T1;
   // Enabled request caught in the last state, or in halt.
   assign int_set = int_s && irq_enable_flag && !int_latch_reg &&
                    (last_state || state_reg == S_HALT);
   assign int_take = (int_latch_reg || int_set) && state_next == S_T1;
   assign is_rst = (data_in & RST_MASK) == RST_MATCH;
   assign hold_set = (state_reg == S_T2 || state_reg == S_TW) && ready_s && hold_s;
   assign rst_hit = state_reg == S_T3 && (cyc_fetch || int_cycle_reg) && is_rst;
   assign rst_target = {10'h000, data_in[RST_FIELD_LSB +: 3], 3'h0};

   // Next state of the machine-cycle sequencer.
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         S_T1: state_next = S_T2;
         S_T2, S_TW: begin
            if (!ready_s) begin
               state_next = S_TW;
            end else if (halt_pend_reg) begin
               state_next = S_HALT;
            end else begin
               state_next = S_T3;
            end
         end
         S_T3: state_next = (cyc_len > CYC_LEN_MIN) ? S_T4 : end_state;
         S_T4: state_next = (cyc_len > CYC_LEN_MID) ? S_T5 : end_state;
         S_T5: state_next = end_state;
         S_HALT: begin
            if (hold_s) begin
               state_next = S_HOLD;
            end else if (int_s && irq_enable_flag) begin
               state_next = S_T1;
            end
         end
         S_HOLD: begin
            if (!hold_s) begin
               state_next = halt_ret_reg ? S_HALT : S_T1;
            end
         end
         default: state_next = S_T1;
      endcase
      if (reset_s) begin
         state_next = S_T1;
      end
   end

   // State register.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= S_T1;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------
   // Hold, halt and interrupt latches
   // ----------------------------------------------------------------
   // Hold latch sets in T2 or wait when ready and hold coincide.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_latch_reg <= 1'b0;
         halt_ret_reg <= 1'b0;
      end else if (reset_s) begin
         hold_latch_reg <= 1'b0;
         halt_ret_reg <= 1'b0;
      end else if (hold_set) begin
         hold_latch_reg <= 1'b1;
      end else if (state_reg == S_HALT && hold_s) begin
         hold_latch_reg <= 1'b1;
         halt_ret_reg <= 1'b1;
      end else if (state_reg == S_HOLD && !hold_s) begin
         hold_latch_reg <= 1'b0;
         halt_ret_reg <= 1'b0;
      end
   end

   // Halt is pending from its execution until the halt wait state.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         halt_pend_reg <= 1'b0;
      end else if (reset_s || state_reg == S_HALT) begin
         halt_pend_reg <= 1'b0;
      end else if (halt_instruction) begin
         halt_pend_reg <= 1'b1;
      end
   end

   // Interrupt latch, interrupt cycle marker and enable flag.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         int_latch_reg <= 1'b0;
         int_cycle_reg <= 1'b0;
         irq_enable_flag <= 1'b0;
      end else if (reset_s) begin
         int_latch_reg <= 1'b0;
         int_cycle_reg <= 1'b0;
         irq_enable_flag <= 1'b0;
      end else begin
         if (int_take) begin
            int_latch_reg <= 1'b0;
         end else if (int_set) begin
            int_latch_reg <= 1'b1;
         end
         if (state_next == S_T1) begin
            int_cycle_reg <= int_take;
         end
         if (int_set) begin
            irq_enable_flag <= 1'b0;
         end else if (ie_set) begin
            irq_enable_flag <= 1'b1;
         end else if (ie_clr) begin
            irq_enable_flag <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Program counter and restart
   // ----------------------------------------------------------------
   // Counter steps in T2 except in the interrupt cycle; restart loads a vector.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pc_reg <= PC_RESET;
         push_req <= 1'b0;
         push_data <= PC_RESET;
         instr_out <= 8'h00;
      end else if (reset_s) begin
         pc_reg <= PC_RESET;
         push_req <= 1'b0;
      end else begin
         push_req <= 1'b0;
         if (state_reg == S_T3 && (cyc_fetch || int_cycle_reg)) begin
            instr_out <= data_in;
            if (is_rst) begin
               push_req <= 1'b1;
               push_data <= pc_reg;
               pc_reg <= rst_target;
            end
         end else if (state_reg == S_T2 && cyc_pc_src && !int_cycle_reg) begin
            pc_reg <= pc_reg + 16'h0001;
         end else if (pc_load) begin
            pc_reg <= pc_load_value;
         end
      end
   end
   assign pc_out = pc_reg;

   // ----------------------------------------------------------------
   // Bus outputs
   // ----------------------------------------------------------------
   logic grant_next, in_t1_next;
   logic [7:0] status_next;

   assign in_t1_next = state_next == S_T1;
   // Grant at T3 for reads, else after T3; drop when hold leaves.
   always_comb begin
      grant_next = bus_grant_ack;
      if (reset_s || (state_reg == S_HOLD && !hold_s)) begin
         grant_next = 1'b0;
      end else if ((hold_latch_reg || hold_set) && state_next == S_T3 && cyc_read) begin
         grant_next = 1'b1;
      end else if (hold_latch_reg && state_reg == S_T3 && !cyc_read) begin
         grant_next = 1'b1;
      end else if (state_next == S_HOLD) begin
         grant_next = 1'b1;
      end
   end

   // Status byte for the next cycle, with interrupt bits on top.
   always_comb begin
      status_next = cyc_status_misc;
      status_next[ST_READ] = cyc_read || int_take;
      status_next[ST_MEM_READ] = cyc_fetch && !int_take;
      status_next[ST_HALT_ACK] = halt_pend_reg;
      status_next[ST_FIRST_FETCH] = cyc_fetch || int_take;
      status_next[ST_IRQ_ACK] = int_take;
   end

   // Registered pins: state, status, strobe, grant, address and data.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_out <= 8'h01;
         sync_out <= 1'b0;
         first_fetch_status <= 1'b0;
         irq_ack_status <= 1'b0;
         data_in_strobe <= 1'b0;
         bus_grant_ack <= 1'b0;
         addr_out <= 16'h0000;
         addr_oe <= 1'b0;
         data_out <= 8'h00;
         data_oe <= 1'b0;
      end else begin
         state_out <= state_next;
         sync_out <= in_t1_next;
         if (in_t1_next) begin
            first_fetch_status <= status_next[ST_FIRST_FETCH];
            irq_ack_status <= status_next[ST_IRQ_ACK];
         end
         data_in_strobe <= (state_next == S_T2 || state_next == S_TW) &&
                           (cyc_read || int_cycle_reg);
         bus_grant_ack <= grant_next;
         addr_oe <= !(bus_grant_ack && grant_next);
         if (in_t1_next) begin
            addr_out <= (cyc_pc_src || int_take) ? (rst_hit ? rst_target : pc_reg) :
                        cyc_addr;
            data_out <= status_next;
         end else if (state_next == S_T3 && !cyc_read && !int_cycle_reg) begin
            data_out <= cyc_wdata;
         end
         data_oe <= !(bus_grant_ack && grant_next) && (in_t1_next ||
                    (!cyc_read && !int_cycle_reg && state_next == S_T3));
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_int_status_pair: assert property (sync_out && irq_ack_status |->
      first_fetch_status && data_out[ST_IRQ_ACK] && data_out[ST_FIRST_FETCH])
      else $error("interrupt status bits not paired");
   a_int_pc_kept: assert property (int_cycle_reg && state_reg == S_T2 && !pc_load && !reset_s
      |=> $stable(pc_reg))
      else $error("counter moved in interrupt cycle");
   a_rst_vector: assert property (state_reg == S_T3 && int_cycle_reg && is_rst && !reset_s
      |=> push_req && pc_reg[2:0] == 3'h0 && pc_reg[15:6] == 10'h000)
      else $error("restart vector not taken");
   a_grant_read_t3: assert property ((hold_latch_reg || hold_set) && cyc_read && !reset_s &&
      state_next == S_T3 |=> bus_grant_ack)
      else $error("grant late in read cycle");
   a_float_after_grant: assert property ($rose(bus_grant_ack) |=> !addr_oe && !data_oe)
      else $error("buses not released after grant");
   a_reset_to_t1: assert property (reset_s |=> state_reg == S_T1 && pc_reg == PC_RESET)
      else $error("reset did not return to T1");
   a_halt_hold: assert property (state_reg == S_HALT && hold_s && !reset_s
      |=> state_reg == S_HOLD ##0 bus_grant_ack)
      else $error("hold not taken from halt");
   a_halt_int_exit: assert property (state_reg == S_HALT && !hold_s && !reset_s &&
      int_s && irq_enable_flag |=> state_reg == S_T1 ##0 int_cycle_reg)
      else $error("interrupt did not leave halt");
   a_ie_cleared: assert property (int_set && !reset_s |=> !irq_enable_flag)
      else $error("enable flag kept after accept");
   a_data_in_strobe_int: assert property (int_cycle_reg && state_reg == S_T1 && !reset_s &&
      ready_s ##1 state_reg == S_T2 |-> data_in_strobe)
      else $error("no data-in strobe in interrupt cycle");

   c_int_cycle: cover property (sync_out && irq_ack_status);
   c_hold_grant: cover property ($rose(bus_grant_ack) ##[1:20] $fell(bus_grant_ack));
   c_halt_enter: cover property (state_reg == S_HALT);
   c_halt_hold: cover property (state_reg == S_HALT ##1 state_reg == S_HOLD);

endmodule : cpu_seq_ctl

// ### hdl/cpu_seq_pkg.sv
package cpu_seq_pkg;

   // ----------------------------------------------------------------
   // Machine states, one-hot
   // ----------------------------------------------------------------
   typedef enum logic [7:0] {
      S_T1   = 8'h01,
      S_T2   = 8'h02,
      S_TW   = 8'h04,
      S_T3   = 8'h08,
      S_T4   = 8'h10,
      S_T5   = 8'h20,
      S_HALT = 8'h40,
      S_HOLD = 8'h80
   } cpu_state_t;

   // ----------------------------------------------------------------
   // Status byte bit positions and widths
   // ----------------------------------------------------------------
   localparam int ST_IRQ_ACK = 0;
   localparam int ST_READ = 1;
   localparam int ST_HALT_ACK = 3;
   localparam int ST_FIRST_FETCH = 5;
   localparam int ST_MEM_READ = 7;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam logic [15:0] PC_RESET = 16'h0000;

   // Restart opcode pattern 11nnn111 and its vector field.
   localparam logic [7:0] RST_MASK = 8'hc7;
   localparam logic [7:0] RST_MATCH = 8'hc7;
   localparam int RST_FIELD_LSB = 3;

   // Machine cycle lengths in states.
   localparam logic [2:0] CYC_LEN_MIN = 3'h3;
   localparam logic [2:0] CYC_LEN_MID = 3'h4;
   localparam logic [2:0] CYC_LEN_MAX = 3'h5;

   // Core clock period and synchroniser depth.
   localparam int CLK_PERIOD_NS = 40;
   localparam int SYNC_STAGES = 2;

endpackage : cpu_seq_pkg

// ### hdl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync
   import cpu_seq_pkg::*;
#(
   parameter int WIDTH = 4
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_out
);

   logic [WIDTH-1:0] meta_reg;

   initial begin
      if (WIDTH < 1) begin
         $error("pin_sync needs at least one bit");
      end
   end

   // Two flip-flops per pin; the first stage feeds only the second.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= '0;
         pin_out <= '0;
      end else begin
         meta_reg <= pin_in;
         pin_out <= meta_reg;
      end
   end

endmodule : pin_sync

// ### test/periph_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Interrupting peripheral and bus master
// ----------------------------------------------------------------
module periph_model
   import cpu_seq_pkg::*;
(
   input wire logic core_clk,
   input wire logic [7:0] state_out,
   input wire logic irq_ack_status,
   input wire logic bus_grant_ack,
   input wire logic int_go,
   input wire logic [2:0] int_vec,
   input wire logic hold_go,
   input wire logic [7:0] hold_cycles,
   output logic int_req,
   output logic hold_req,
   output logic [7:0] data_in
);
   logic served_reg = 1'b0;
   logic done_reg = 1'b0;
   logic [7:0] cnt_reg = 8'h00;
   logic jam;

   // The request stays up until the acknowledge status is seen.
   always_ff @(posedge core_clk) begin
      if (!int_go) served_reg <= 1'b0;
      else if (irq_ack_status) served_reg <= 1'b1;
      int_req <= int_go && !served_reg && !irq_ack_status;
   end

   // The master keeps the bus for a set time, then drops the request.
   always_ff @(posedge core_clk) begin
      if (!hold_go) begin
         done_reg <= 1'b0;
         cnt_reg <= 8'h00;
      end else if (bus_grant_ack && cnt_reg < hold_cycles) begin
         cnt_reg <= cnt_reg + 8'h01;
      end else if (bus_grant_ack) begin
         done_reg <= 1'b1;
      end
      hold_req <= hold_go && !done_reg && !(bus_grant_ack && cnt_reg >= hold_cycles);
   end

   // The restart byte is jammed while the interrupt cycle reads the bus.
   assign jam = irq_ack_status && (state_out == S_T2 || state_out == S_TW || state_out == S_T3);
   assign data_in = jam ? {2'b11, int_vec, 3'b111} : 8'h00;
endmodule : periph_model

// ### test/test_cpu_seq_ctl.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
   compares++; \
   if ((got) !== (ex)) begin \
      $display("BAD %s exp %h got %h", nm, ex, got); \
      n_mismatch++; \
   end
`define WAITC(c) \
   for (int i = 0; i < 80 && !(c); i++) tick(); \
   if (!(c)) begin \
      $display("BAD wait exp 1 got 0"); \
      n_mismatch++; \
   end
module test_cpu_seq_ctl
   import cpu_seq_pkg::*;
;
   logic core_clk = 1'b0, nrst = 1'b0, ready = 1'b1, cpu_reset = 1'b0;
   logic [2:0] cyc_len = 3'h3;
   logic cyc_read = 1'b1, cyc_fetch = 1'b1, cyc_pc_src = 1'b1;
   logic [15:0] cyc_addr = 16'h0000;
   logic [7:0] cyc_wdata = 8'h00;
   logic halt_instruction = 1'b0, ie_set = 1'b0, ie_clr = 1'b0, cyc_last = 1'b1;
   logic int_go = 1'b0, hold_go = 1'b0;
   logic [2:0] int_vec = 3'h0;
   logic [7:0] hold_cycles = 8'h04;
   logic int_req, hold_req, sync_out, first_fetch_status, irq_ack_status, irq_enable_flag;
   logic data_in_strobe, bus_grant_ack, addr_oe, data_oe, push_req;
   logic [7:0] data_in, state_out, data_out, instr_out, prev_st;
   logic [15:0] addr_out, pc_out, push_data, pc_old;
   int n_mismatch = 0;
   int compares = 0;

   // ----------------------------------------------------------------
   // Clock, design and partner
   // ----------------------------------------------------------------
   initial begin
      forever #20 core_clk = ~core_clk;
   end

   cpu_seq_ctl uut (.core_clk(core_clk), .nrst(nrst), .int_req(int_req), .hold_req(hold_req),
      .ready(ready), .cpu_reset(cpu_reset), .cyc_len(cyc_len), .cyc_read(cyc_read),
      .cyc_fetch(cyc_fetch), .cyc_pc_src(cyc_pc_src), .cyc_last(cyc_last),
      .cyc_status_misc(8'h00), .cyc_addr(cyc_addr), .cyc_wdata(cyc_wdata),
      .halt_instruction(halt_instruction), .ie_set(ie_set), .ie_clr(ie_clr),
      .pc_load(1'b0), .pc_load_value(16'h0000), .data_in(data_in), .state_out(state_out),
      .sync_out(sync_out), .first_fetch_status(first_fetch_status),
      .irq_ack_status(irq_ack_status), .irq_enable_flag(irq_enable_flag),
      .data_in_strobe(data_in_strobe), .bus_grant_ack(bus_grant_ack), .addr_out(addr_out),
      .addr_oe(addr_oe), .data_out(data_out), .data_oe(data_oe), .pc_out(pc_out),
      .instr_out(instr_out), .push_req(push_req), .push_data(push_data));

   periph_model peer (.core_clk(core_clk), .state_out(state_out),
      .irq_ack_status(irq_ack_status), .bus_grant_ack(bus_grant_ack), .int_go(int_go),
      .int_vec(int_vec), .hold_go(hold_go), .hold_cycles(hold_cycles), .int_req(int_req),
      .hold_req(hold_req), .data_in(data_in));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic tick();
      prev_st = state_out;
      @(posedge core_clk);
      #1;
   endtask : tick

   task automatic report_and_stop();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : report_and_stop

   task automatic pulse_ie();
      @(posedge core_clk) ie_set <= 1'b1;
      @(posedge core_clk) ie_set <= 1'b0;
      tick();
      `CHK("flag", 1'b1, irq_enable_flag)
   endtask : pulse_ie

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic irq_case(input logic [2:0] n);
      pulse_ie();
      @(posedge core_clk) begin int_vec <= n; int_go <= 1'b1; end
      `WAITC(irq_ack_status === 1'b1 && sync_out === 1'b1)
      `CHK("ack", 1'b1, irq_ack_status)
      `CHK("m1", 1'b1, first_fetch_status)
      `CHK("d0d5", 2'b11, {data_out[5], data_out[0]})
      `CHK("flag_clr", 1'b0, irq_enable_flag)
      pc_old = pc_out;
      `CHK("addr_t1", pc_old, addr_out)
      int_go <= 1'b0;
      tick();
      `CHK("strobe", 1'b1, data_in_strobe)
      `WAITC(state_out === S_T3)
      `CHK("pc_kept", pc_old, pc_out)
      `WAITC(push_req === 1'b1)
      `CHK("push", pc_old, push_data)
      `CHK("instr", {2'b11, n, 3'b111}, instr_out)
      `WAITC(sync_out === 1'b1)
      `CHK("target", {10'h000, n, 3'h0}, addr_out)
   endtask : irq_case

   task automatic hold_read();
      @(posedge core_clk) begin cyc_len <= 3'h5; hold_go <= 1'b1; end
      `WAITC(bus_grant_ack === 1'b1)
      `CHK("grant_t3", S_T3, state_out)
      tick();
      `CHK("float", 2'b00, {addr_oe, data_oe})
      `CHK("t4", S_T4, state_out)
      tick();
      `CHK("t5", S_T5, state_out)
      tick();
      `CHK("hold", S_HOLD, state_out)
      `WAITC(bus_grant_ack === 1'b0)
      hold_go <= 1'b0;
      `WAITC(sync_out === 1'b1)
      `CHK("resume", S_HOLD, prev_st)
      `CHK("status_oe", 2'b11, {addr_oe, data_oe})
   endtask : hold_read

   task automatic hold_write();
      @(posedge core_clk) begin
         cyc_read <= 1'b0; cyc_fetch <= 1'b0; cyc_pc_src <= 1'b0; cyc_len <= 3'h4;
         cyc_addr <= 16'h2345; cyc_wdata <= 8'h5a;
      end
      tick();
      tick();
      `WAITC(sync_out === 1'b1)
      `CHK("addr_np", 16'h2345, addr_out)
      hold_go <= 1'b1;
      `WAITC(bus_grant_ack === 1'b1)
      `CHK("grant_wr", S_T3, prev_st)
      `WAITC(bus_grant_ack === 1'b0)
      hold_go <= 1'b0;
      cyc_read <= 1'b1; cyc_fetch <= 1'b1; cyc_pc_src <= 1'b1; cyc_len <= 3'h3;
      tick();
   endtask : hold_write

   task automatic halt_case();
      @(posedge core_clk) halt_instruction <= 1'b1;
      @(posedge core_clk) halt_instruction <= 1'b0;
      `WAITC(state_out === S_HALT)
      `CHK("halt_t2", S_T2, prev_st)
      hold_go <= 1'b1;
      `WAITC(state_out === S_HOLD)
      `CHK("halt_hold", 1'b1, bus_grant_ack)
      `WAITC(state_out !== S_HOLD)
      hold_go <= 1'b0;
      `CHK("back_halt", S_HALT, state_out)
      int_go <= 1'b1;
      repeat (30) tick();
      `CHK("stay_halt", S_HALT, state_out)
      int_go <= 1'b0;
      cpu_reset <= 1'b1;
      repeat (4) tick();
      `CHK("rst_st", S_T1, state_out)
      `CHK("rst_pc", 16'h0000, pc_out)
      cpu_reset <= 1'b0;
      repeat (2) tick();
      pulse_ie();
      @(posedge core_clk) halt_instruction <= 1'b1;
      @(posedge core_clk) begin halt_instruction <= 1'b0; int_vec <= 3'h3; end
      `WAITC(state_out === S_HALT)
      int_go <= 1'b1;
      `WAITC(state_out !== S_HALT)
      `CHK("int_exit", S_T1, state_out)
      `WAITC(irq_ack_status === 1'b1)
      `CHK("int_ack", 1'b1, irq_ack_status)
      int_go <= 1'b0;
   endtask : halt_case

   task automatic ready_case();
      @(posedge core_clk) ready <= 1'b0;
      #1;
      `WAITC(state_out === S_TW)
      `CHK("tw", S_TW, state_out)
      `CHK("tw_strobe", 1'b1, data_in_strobe)
      @(posedge core_clk) ready <= 1'b1;
      #1;
      `WAITC(state_out === S_T3)
      `CHK("t3", S_T3, state_out)
   endtask : ready_case

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      repeat (10) @(posedge core_clk);
      nrst <= 1'b1;
      tick();
      `CHK("rst_state", S_T1, state_out)
      `CHK("rst_pc0", 16'h0000, pc_out)
      `CHK("rst_grant", 1'b0, bus_grant_ack)
      repeat (3) tick();
      ready_case();
      for (int n = 0; n < 8; n++) irq_case(3'(n));
      pulse_ie();
      @(posedge core_clk) ie_clr <= 1'b1;
      @(posedge core_clk) ie_clr <= 1'b0;
      #1;
      `CHK("flag_off", 1'b0, irq_enable_flag)
      int_go <= 1'b1;
      repeat (40) tick();
      `CHK("refused", 1'b0, irq_ack_status)
      int_go <= 1'b0;
      repeat (4) tick();
      pulse_ie();
      @(posedge core_clk) begin cyc_last <= 1'b0; int_go <= 1'b1; end
      repeat (20) tick();
      `CHK("mid_instr", 1'b0, irq_ack_status)
      @(posedge core_clk) cyc_last <= 1'b1;
      #1;
      `WAITC(irq_ack_status === 1'b1)
      `CHK("last_state", 1'b1, irq_ack_status)
      int_go <= 1'b0;
      repeat (4) tick();
      hold_read();
      hold_write();
      halt_case();
      report_and_stop();
   end

   // A hang is cut short well after the sequence should have ended.
   initial begin
      #(CLK_PERIOD_NS * 20000);
      n_mismatch++;
      report_and_stop();
   end
endmodule : test_cpu_seq_ctl
